// [src/fnps_pkg.sv]
package fnps_pkg;

  // ==========================================================
  // Register offsets from the memory base
  localparam logic [31:0] OFF_FRAME_INTERVAL = 32'h0000_0034;
  localparam logic [31:0] OFF_FRAME_REMAINING = 32'h0000_0038;
  localparam logic [31:0] OFF_FRAME_NUMBER = 32'h0000_003c;
  localparam logic [31:0] OFF_PERIODIC_THRESHOLD = 32'h0000_0040;

  // ==========================================================
  // Field widths and positions
  localparam int COUNT_W = 14;
  localparam int FRAME_COUNT_W = 16;
  localparam int FIELD_LSB = 0;
  localparam int LARGEST_PACKET_LSB = 16;
  localparam int LARGEST_PACKET_W = 15;
  localparam int TOGGLE_BIT = 31;

  // ==========================================================
  // Reset values and the frame number wrap point
  localparam logic [13:0] FRAME_INTERVAL_NOMINAL = 14'h2edf; // 11,999
  localparam logic [14:0] LARGEST_PACKET_RESET = 15'h0000;
  localparam logic [15:0] FRAME_NUMBER_RESET = 16'h0000;
  localparam logic [13:0] PERIODIC_THRESHOLD_RESET = 14'h0000;
  localparam logic [13:0] FRAME_REMAINING_RESET = 14'h0000;
  localparam logic [15:0] FRAME_NUMBER_MAX = 16'hffff;

  // ==========================================================
  // Frame start sequence
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_SOF,
    SEQ_STORE,
    SEQ_FLAG
  } frame_seq_t;

endpackage : fnps_pkg

// [src/frame_if.sv]
`timescale 1ns/1ps

// ==========================================================
// Link between frame control and the remaining-time counter
interface frame_if;
  logic [13:0] interval;
  logic fit;
  logic run;
  logic tick;
  logic reload_req;
  logic [13:0] remaining;
  logic frt;
  logic boundary;

  modport timer (
    input interval,
    input fit,
    input run,
    input tick,
    input reload_req,
    output remaining,
    output frt,
    output boundary
  );

  modport ctrl (
    output interval,
    output fit,
    output run,
    output tick,
    output reload_req,
    input remaining,
    input frt,
    input boundary
  );
endinterface : frame_if

// [src/frame_remaining_timer.sv]
`timescale 1ns/1ps

// ==========================================================
// Bit-time down counter that marks frame boundaries
module frame_remaining_timer (
  input wire logic clk,
  input wire logic rst_n,
  frame_if.timer fif
);

  logic [13:0] next_remaining;
  logic next_frt;
  logic next_boundary;

  // Count down per bit time, reload from the interval at zero
  always_comb begin
    next_remaining = fif.remaining;
    next_frt = fif.frt;
    next_boundary = 1'b0;
    if (fif.reload_req) begin
      next_remaining = fif.interval;
      next_frt = fif.fit;
    end else if (fif.run && fif.tick) begin
      if (fif.remaining == '0) begin
        next_remaining = fif.interval;
        next_frt = fif.fit;
        next_boundary = 1'b1;
      end else begin
        next_remaining = fif.remaining - 14'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fif.remaining <= fnps_pkg::FRAME_REMAINING_RESET;
      fif.frt <= 1'b0;
      fif.boundary <= 1'b0;
    end else begin
      fif.remaining <= next_remaining;
      fif.frt <= next_frt;
      fif.boundary <= next_boundary;
    end
  end

endmodule : frame_remaining_timer

// [src/frame_number_periodic_start.sv]
`timescale 1ns/1ps


module frame_number_periodic_start (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] bar_base,
  input wire logic [31:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack,
  input wire logic bit_tick,
  input wire logic operational_state,
  input wire logic list_busy,
  input wire logic sof_done,
  input wire logic area_wr_ack,
  output logic sof_req,
  output logic area_wr_req,
  output logic [15:0] area_wr_data,
  output logic frame_start_flag,
  output logic desc_fetch_en,
  output logic periodic_priority
);

  // ==========================================================
  // Address decode
  function automatic logic reg_hit(input logic [31:0] addr,
                                   input logic [31:0] base,
                                   input logic [31:0] off);
    reg_hit = ((addr - base) == off);
  endfunction : reg_hit

  // ==========================================================
  // State
  logic [13:0] frame_interval;
  logic [14:0] largest_packet;
  logic fit;
  logic [15:0] frame_count;
  logic [13:0] periodic_threshold;
  logic oper_d;
  logic periodic_pending;
  fnps_pkg::frame_seq_t seq;

  logic [13:0] next_frame_interval;
  logic [14:0] next_largest_packet;
  logic next_fit;
  logic [15:0] next_frame_count;
  logic [13:0] next_periodic_threshold;
  logic next_periodic_pending;
  logic next_periodic_priority;
  fnps_pkg::frame_seq_t next_seq;
  logic next_sof_req;
  logic next_area_wr_req;
  logic [15:0] next_area_wr_data;
  logic next_frame_start_flag;
  logic next_desc_fetch_en;
  logic [31:0] next_mem_rdata;
  logic next_mem_ack;

  logic oper_entry;
  logic frame_begin;
  logic hit_interval;
  logic hit_remaining;
  logic hit_number;
  logic hit_threshold;

  frame_if fif ();

  frame_remaining_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .fif(fif)
  );

  // Inputs come from same-clock controller logic, so no synchronisers
  assign oper_entry = operational_state && !oper_d;
  assign frame_begin = fif.boundary || oper_entry;
  assign fif.interval = frame_interval;
  assign fif.fit = fit;
  assign fif.run = operational_state;
  assign fif.tick = bit_tick;
  assign fif.reload_req = oper_entry;

  assign hit_interval = reg_hit(mem_addr, bar_base,
                                fnps_pkg::OFF_FRAME_INTERVAL);
  assign hit_remaining = reg_hit(mem_addr, bar_base,
                                 fnps_pkg::OFF_FRAME_REMAINING);
  assign hit_number = reg_hit(mem_addr, bar_base,
                              fnps_pkg::OFF_FRAME_NUMBER);
  assign hit_threshold = reg_hit(mem_addr, bar_base,
                                 fnps_pkg::OFF_PERIODIC_THRESHOLD);

  // ==========================================================
  // Register file: writes and read mux
  always_comb begin
    next_frame_interval = frame_interval;
    next_largest_packet = largest_packet;
    next_fit = fit;
    next_periodic_threshold = periodic_threshold;
    next_mem_ack = mem_wr || mem_rd;
    next_mem_rdata = mem_rdata;
    // Reserved bits are dropped; software keeps them zero
    if (mem_wr && hit_interval) begin
      next_frame_interval = mem_wdata[13:0];
      next_largest_packet = mem_wdata[30:16];
      next_fit = mem_wdata[fnps_pkg::TOGGLE_BIT];
    end
    if (mem_wr && hit_threshold) begin
      next_periodic_threshold = mem_wdata[13:0];
    end
    if (mem_rd) begin
      next_mem_rdata = 32'h0000_0000; // Unmapped offsets read zero
      if (hit_interval) begin
        next_mem_rdata = {fit, largest_packet, 2'b00, frame_interval};
      end else if (hit_remaining) begin
        next_mem_rdata = {fif.frt, 17'h00000, fif.remaining};
      end else if (hit_number) begin
        next_mem_rdata = {18'h00000, frame_count[13:0]};
      end else if (hit_threshold) begin
        next_mem_rdata = {18'h00000, periodic_threshold};
      end
    end
  end

  // ==========================================================
  // Frame number counter
  always_comb begin
    next_frame_count = frame_count;
    if (frame_begin) begin
      // Hardware step wins over a same-cycle software write
      if (frame_count == fnps_pkg::FRAME_NUMBER_MAX) begin
        next_frame_count = '0;
      end else begin
        next_frame_count = frame_count + 16'h0001;
      end
    end else if (mem_wr && hit_number) begin
      next_frame_count = {2'b00, mem_wdata[13:0]};
    end
  end

  // ==========================================================
  // Frame start sequence: SOF, shared-area write, flag, fetch
  always_comb begin
    next_seq = seq;
    next_sof_req = sof_req;
    next_area_wr_req = area_wr_req;
    next_area_wr_data = area_wr_data;
    next_frame_start_flag = 1'b0;
    next_desc_fetch_en = desc_fetch_en;
    if (frame_begin) begin
      // A new frame restarts the sequence; fetch stays blocked
      next_seq = fnps_pkg::SEQ_SOF;
      next_sof_req = 1'b1;
      next_area_wr_req = 1'b0;
      next_desc_fetch_en = 1'b0;
    end else begin
      unique case (seq)
        fnps_pkg::SEQ_IDLE: begin
          next_desc_fetch_en = operational_state && desc_fetch_en;
        end
        fnps_pkg::SEQ_SOF: begin
          if (sof_done) begin
            next_sof_req = 1'b0;
            next_area_wr_req = 1'b1;
            next_area_wr_data = frame_count;
            next_seq = fnps_pkg::SEQ_STORE;
          end
        end
        fnps_pkg::SEQ_STORE: begin
          if (area_wr_ack) begin
            next_area_wr_req = 1'b0;
            next_frame_start_flag = 1'b1;
            next_seq = fnps_pkg::SEQ_FLAG;
          end
        end
        fnps_pkg::SEQ_FLAG: begin
          next_desc_fetch_en = 1'b1;
          next_seq = fnps_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Periodic priority after the threshold
  always_comb begin
    next_periodic_pending = periodic_pending;
    next_periodic_priority = periodic_priority;
    if (frame_begin) begin
      next_periodic_pending = 1'b0;
      next_periodic_priority = 1'b0;
    end else begin
      if (operational_state && fif.remaining == periodic_threshold) begin
        next_periodic_pending = 1'b1;
      end
      // Running control or bulk work finishes first
      if ((next_periodic_pending) && !list_busy) begin
        next_periodic_priority = 1'b1;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_interval <= fnps_pkg::FRAME_INTERVAL_NOMINAL;
      largest_packet <= fnps_pkg::LARGEST_PACKET_RESET;
      fit <= 1'b0;
      frame_count <= fnps_pkg::FRAME_NUMBER_RESET;
      periodic_threshold <= fnps_pkg::PERIODIC_THRESHOLD_RESET;
      oper_d <= 1'b0;
      periodic_pending <= 1'b0;
      periodic_priority <= 1'b0;
      seq <= fnps_pkg::SEQ_IDLE;
      sof_req <= 1'b0;
      area_wr_req <= 1'b0;
      area_wr_data <= 16'h0000;
      frame_start_flag <= 1'b0;
      desc_fetch_en <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      mem_ack <= 1'b0;
    end else begin
      frame_interval <= next_frame_interval;
      largest_packet <= next_largest_packet;
      fit <= next_fit;
      frame_count <= next_frame_count;
      periodic_threshold <= next_periodic_threshold;
      oper_d <= operational_state;
      periodic_pending <= next_periodic_pending;
      periodic_priority <= next_periodic_priority;
      seq <= next_seq;
      sof_req <= next_sof_req;
      area_wr_req <= next_area_wr_req;
      area_wr_data <= next_area_wr_data;
      frame_start_flag <= next_frame_start_flag;
      desc_fetch_en <= next_desc_fetch_en;
      mem_rdata <= next_mem_rdata;
      mem_ack <= next_mem_ack;
    end
  end

endmodule : frame_number_periodic_start

// [testbench/fnps_checker.sv]
`timescale 1ns/1ps

// ==========================================
// Port checks for the frame number block
module fnps_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] bar_base,
  input wire logic [31:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic operational_state,
  input wire logic list_busy,
  input wire logic sof_done,
  input wire logic area_wr_ack,
  input wire logic sof_req,
  input wire logic area_wr_req,
  input wire logic [15:0] area_wr_data,
  input wire logic frame_start_flag,
  input wire logic desc_fetch_en,
  input wire logic periodic_priority
);
  logic [15:0] last_num;
  logic [15:0] next_last_num;
  logic seen;
  logic next_seen;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Last number stored, so each frame can be tied to the one before
  always_comb begin
    next_last_num = last_num;
    next_seen = seen;
    if (area_wr_req && area_wr_ack) begin
      next_last_num = area_wr_data;
      next_seen = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_num <= 16'h0000;
      seen <= 1'b0;
    end else begin
      last_num <= next_last_num;
      seen <= next_seen;
    end
  end

  // ==========================================
  // Assertions
  a_ack_follows: assert property ((mem_wr || mem_rd) |=> mem_ack)
    else $error("access not acknowledged");
  a_num_upper: assert property ((mem_rd &&
    mem_addr - bar_base == fnps_pkg::OFF_FRAME_NUMBER) |=>
    mem_rdata[31:14] == 18'h00000) else $error("frame number upper bits");
  a_thr_upper: assert property ((mem_rd &&
    mem_addr - bar_base == fnps_pkg::OFF_PERIODIC_THRESHOLD) |=>
    mem_rdata[31:14] == 18'h00000) else $error("threshold upper bits");
  a_num_step: assert property ((area_wr_req && area_wr_ack && seen)
    |-> area_wr_data == last_num + 16'h0001) else $error("frame step");
  a_write_after_sof: assert property ((sof_req && sof_done)
    |=> area_wr_req && !sof_req) else $error("store not after token");
  a_no_early_fetch: assert property ((sof_req || area_wr_req)
    |-> !desc_fetch_en) else $error("fetch before store");
  a_flag_after_store: assert property ((area_wr_req && area_wr_ack)
    |=> frame_start_flag ##1 !frame_start_flag) else $error("flag pulse");
  a_fetch_after_flag: assert property (frame_start_flag
    |=> ##[0:1] desc_fetch_en) else $error("fetch not enabled");
  a_prio_waits: assert property ($rose(periodic_priority)
    |-> !$past(list_busy)) else $error("priority during transfer");
  a_sof_holds: assert property ((sof_req && !sof_done && operational_state)
    |=> sof_req) else $error("token request dropped");

  c_flag: cover property (frame_start_flag);
  c_prio: cover property ($rose(periodic_priority));
  c_read: cover property (mem_rd ##1 mem_ack);
endmodule : fnps_checker

bind frame_number_periodic_start fnps_checker u_chk (.clk(clk),
  .rst_n(rst_n), .bar_base(bar_base), .mem_addr(mem_addr),
  .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
  .mem_ack(mem_ack), .operational_state(operational_state),
  .list_busy(list_busy), .sof_done(sof_done), .area_wr_ack(area_wr_ack),
  .sof_req(sof_req), .area_wr_req(area_wr_req),
  .area_wr_data(area_wr_data), .frame_start_flag(frame_start_flag),
  .desc_fetch_en(desc_fetch_en), .periodic_priority(periodic_priority));

// [testbench/shared_area_model.sv]
`timescale 1ns/1ps

// ==========================================
// Host memory holding the shared area
module shared_area_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] slow,
  input wire logic sof_req,
  input wire logic area_wr_req,
  input wire logic [15:0] area_wr_data,
  output logic sof_done,
  output logic area_wr_ack,
  output logic [15:0] shared_frame
);
  logic [3:0] waited;

  // Answer after slow idle cycles; single pulses so no stale ack lingers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sof_done <= 1'b0;
      area_wr_ack <= 1'b0;
      shared_frame <= 16'h0000;
      waited <= 4'h0;
    end else begin
      sof_done <= 1'b0;
      area_wr_ack <= 1'b0;
      if ((sof_req && !sof_done) || (area_wr_req && !area_wr_ack)) begin
        if (waited >= slow) begin
          waited <= 4'h0;
          sof_done <= sof_req;
          area_wr_ack <= !sof_req;
          if (!sof_req) shared_frame <= area_wr_data;
        end else begin
          waited <= waited + 4'h1;
        end
      end
    end
  end
endmodule : shared_area_model

// [testbench/frame_number_periodic_start_bench.sv]
`timescale 1ns/1ps

// ==========================================
// Bench for frame number and periodic start
module frame_number_periodic_start_bench;
  logic clk, rst_n, mem_wr, mem_rd, mem_ack, bit_tick, operational_state;
  logic list_busy, sof_done, area_wr_ack, sof_req, area_wr_req;
  logic frame_start_flag, desc_fetch_en, periodic_priority;
  logic [31:0] bar_base, mem_addr, mem_wdata, mem_rdata, rd_val;
  logic [15:0] area_wr_data, shared_frame;
  logic [3:0] slow;
  int n_fail, compares, cycles, i;

  frame_number_periodic_start u_dut (.clk(clk), .rst_n(rst_n),
    .bar_base(bar_base), .mem_addr(mem_addr), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .bit_tick(bit_tick),
    .operational_state(operational_state), .list_busy(list_busy),
    .sof_done(sof_done), .area_wr_ack(area_wr_ack), .sof_req(sof_req),
    .area_wr_req(area_wr_req), .area_wr_data(area_wr_data),
    .frame_start_flag(frame_start_flag), .desc_fetch_en(desc_fetch_en),
    .periodic_priority(periodic_priority));

  shared_area_model u_mem (.clk(clk), .rst_n(rst_n), .slow(slow),
    .sof_req(sof_req), .area_wr_req(area_wr_req),
    .area_wr_data(area_wr_data), .sof_done(sof_done),
    .area_wr_ack(area_wr_ack), .shared_frame(shared_frame));

  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One-cycle strobe; ack and data are registered on the taking edge and read 1 ns after it
  task automatic access(input logic wr, input logic [31:0] off,
                        input logic [31:0] data);
    @(posedge clk);
    #1 mem_addr = bar_base + off;
    mem_wr = wr;
    mem_rd = !wr;
    mem_wdata = data;
    @(posedge clk);
    #1 mem_wr = 1'b0;
    mem_rd = 1'b0;
    rd_val = mem_rdata;
    check({31'h0, mem_ack}, 32'h1);
  endtask : access

  // Step past the pulse of an earlier frame before looking for a new one
  task automatic wait_flag();
    @(posedge clk);
    #1;
    for (i = 0; i < 200 && frame_start_flag !== 1'b1; i++) @(posedge clk) #1;
    check({31'h0, frame_start_flag}, 32'h1);
  endtask : wait_flag

  task automatic print_verdict();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // ==========================================
  // Main sequence
  initial begin
    {rst_n, mem_wr, mem_rd, bit_tick, operational_state, list_busy} = 6'h00;
    {n_fail, compares, cycles} = 0;
    bar_base = 32'h1000_0000;
    {mem_addr, mem_wdata} = 64'h0;
    slow = 4'h0;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    access(1'b0, 32'h34, 32'h0); check(rd_val, 32'h2edf);
    access(1'b0, 32'h3c, 32'h0); check(rd_val, 32'h0);
    access(1'b0, 32'h40, 32'h0); check(rd_val, 32'h0);
    access(1'b0, 32'h44, 32'h0); check(rd_val, 32'h0);
    access(1'b1, 32'h40, 32'h3e67);
    access(1'b0, 32'h40, 32'h0); check(rd_val, 32'h3e67);
    access(1'b1, 32'h40, 32'h000a);
    access(1'b1, 32'h34, 32'h0028);
    access(1'b1, 32'h3c, 32'h3fff);
    access(1'b0, 32'h3c, 32'h0); check(rd_val, 32'h3fff);
    // Operational entry steps the number and starts a frame
    bit_tick = 1'b1;
    list_busy = 1'b1;
    operational_state = 1'b1;
    wait_flag();
    check({16'h0, shared_frame}, 32'h4000);
    access(1'b0, 32'h3c, 32'h0); check(rd_val, 32'h0);
    // Threshold passes during a transfer; priority waits for it to end
    for (i = 0; i < 40; i++) begin
      access(1'b0, 32'h38, 32'h0);
      if (rd_val[13:0] < 14'h000a) break;
    end
    check({31'h0, periodic_priority}, 32'h0);
    list_busy = 1'b0;
    repeat (2) @(posedge clk);
    #1 check({31'h0, periodic_priority}, 32'h1);
    wait_flag();
    check({16'h0, shared_frame}, 32'h4001);
    check({31'h0, periodic_priority}, 32'h0);
    slow = 4'h3;
    wait_flag();
    check({16'h0, shared_frame}, 32'h4002);
    operational_state = 1'b0;
    repeat (3) @(posedge clk);
    #1 operational_state = 1'b1;
    wait_flag();
    check({16'h0, shared_frame}, 32'h4003);
    print_verdict();
  end
endmodule : frame_number_periodic_start_bench
